/* File: core/osc_stab_pkg.sv */
// constants and helpers shared by the oscillation stabilization timer
// Notes on behaviour
// - status clears to 00h on reset release, stop instruction, crystal stop write
// - status bits 4..0 flag 2^11,2^13,2^14,2^15,2^16 crystal cycles; 7..5 zero
// - flags rise in ascending order from the 2^11 flag and stay set
// - counter stops at the selected stabilization time, never beyond
// - after stop release only flags up to the selected time can set
// - any system reset loads the select register with 05h (2^16 cycles)
// - with crystal as cpu clock, cpu held after release until time elapses
// - only real crystal edges are counted, start-up delay is excluded
// - status is read-only, readable as a single bit or as a byte
// - select register is read and written as a whole byte
// - stop mode halts the crystal and the internal high-speed oscillator
package osc_stab_pkg;

    // register addresses in the cpu data space
    localparam logic [15:0] STATUS_ADDR = 16'hffa3;
    localparam logic [15:0] SELECT_ADDR = 16'hffa4;

    // values after reset
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [2:0] SELECT_RST = 3'h5;

    // field layout
    localparam int SEL_W   = 3;
    localparam int FLAG_N  = 5;
    localparam int CNT_W   = 17;
    localparam int SYNC_N  = 2;

    // select codes
    localparam logic [2:0] SEL_2P11 = 3'h1;
    localparam logic [2:0] SEL_2P13 = 3'h2;
    localparam logic [2:0] SEL_2P14 = 3'h3;
    localparam logic [2:0] SEL_2P15 = 3'h4;
    localparam logic [2:0] SEL_2P16 = 3'h5;

    // threshold exponents in crystal cycles
    localparam int EXP_2P11 = 11;
    localparam int EXP_2P13 = 13;
    localparam int EXP_2P14 = 14;
    localparam int EXP_2P15 = 15;
    localparam int EXP_2P16 = 16;

    // status flag bit positions
    localparam int POS_2P11 = 4;
    localparam int POS_2P13 = 3;
    localparam int POS_2P14 = 2;
    localparam int POS_2P15 = 1;
    localparam int POS_2P16 = 0;

    // exponent chosen by a select code; prohibited codes act as the longest
    function automatic int sel_exp(input logic [2:0] code);
        case (code)
            SEL_2P11: sel_exp = EXP_2P11;
            SEL_2P13: sel_exp = EXP_2P13;
            SEL_2P14: sel_exp = EXP_2P14;
            SEL_2P15: sel_exp = EXP_2P15;
            default:  sel_exp = EXP_2P16;
        endcase
    endfunction : sel_exp

    // exponent reported by a status bit position
    function automatic int flag_exp(input int pos);
        case (pos)
            POS_2P11: flag_exp = EXP_2P11;
            POS_2P13: flag_exp = EXP_2P13;
            POS_2P14: flag_exp = EXP_2P14;
            POS_2P15: flag_exp = EXP_2P15;
            default:  flag_exp = EXP_2P16;
        endcase
    endfunction : flag_exp

    // cycle count for an exponent, shortened by shift in simulation
    function automatic logic [CNT_W-1:0] thr(input int e, input int shift);
        thr = CNT_W'(1) << (e - shift);
    endfunction : thr

endpackage : osc_stab_pkg

/* File: core/crystal_edge_sync.sv */
// two-stage synchroniser for the crystal pin with rising edge pulse
`timescale 1ns/100ps
module crystal_edge_sync
    import osc_stab_pkg::*;
(
    // clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_rst_n,
    // crystal pin and edge pulse
    input  wire logic i_pin,
    output logic      o_rise
);

    logic [SYNC_N-1:0] sync_q;
    logic              last_q;

    // edge detector reads only the second stage, never the first
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            sync_q <= '0;
            last_q <= 1'b0;
        end
        else
        begin
            sync_q <= {sync_q[SYNC_N-2:0], i_pin};
            last_q <= sync_q[SYNC_N-1];
        end
    end

    assign o_rise = sync_q[SYNC_N-1] & ~last_q;

endmodule : crystal_edge_sync

/* File: core/stab_counter.sv */
// saturating up-counter of crystal edges with programmable limit
`timescale 1ns/100ps
module stab_counter
    import osc_stab_pkg::*;
#(
    parameter int W = CNT_W
)
(
    // clock and reset
    input  wire logic         i_sys_clk,
    input  wire logic         i_rst_n,
    // control
    input  wire logic         i_clr,
    input  wire logic         i_tick,
    input  wire logic [W-1:0] i_limit,
    // state
    output logic [W-1:0]      o_count,
    output logic              o_at_limit
);

    logic [W-1:0] count_q;
    logic [W-1:0] count_d;

    assign o_at_limit = (count_q >= i_limit);
    // clear beats a tick; no advance once the limit is reached
    assign count_d = i_clr ? '0 :
                     (i_tick && !o_at_limit) ? count_q + W'(1) :
                     count_q;

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
            count_q <= '0;
        else
            count_q <= count_d;
    end

    assign o_count = count_q;

endmodule : stab_counter

/* File: core/osc_stab_timer.sv */
// oscillation stabilization timer: status and select registers, stop wait
`timescale 1ns/100ps
module osc_stab_timer
    import osc_stab_pkg::*;
#(
    // shortens every threshold by this power of two for simulation
    parameter int SCALE_SHIFT = 0
)
(
    // clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    // cpu data space access
    input  wire logic [15:0] i_addr,
    input  wire logic        i_wr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_rd,
    input  wire logic [2:0]  i_bit_idx,
    output logic [7:0]       o_rdata,
    output logic             o_rd_bit,
    // crystal pin
    input  wire logic        i_crystal_clock,
    // standby control
    input  wire logic        i_stop_exec,
    input  wire logic        i_stop_release,
    input  wire logic        i_crystal_osc_stop_set,
    input  wire logic        i_cpu_on_crystal,
    // oscillator and cpu control
    output logic             o_osc_halt,
    output logic             o_cpu_hold
);

    typedef enum logic [1:0] {ST_RUN, ST_STOPPED, ST_WAIT} mode_t;

    mode_t             mode_q;
    mode_t             mode_d;
    logic [SEL_W-1:0]  sel_q;
    logic [FLAG_N-1:0] status_q;
    logic [FLAG_N-1:0] status_d;
    logic [FLAG_N-1:0] hit;
    logic [FLAG_N-1:0] allowed;
    logic [7:0]        rdata_q;
    logic              rd_bit_q;
    logic [7:0]        rd_mux;
    logic              crystal_rise;
    logic              tick;
    logic              clr;
    logic [CNT_W-1:0]  count;
    logic [CNT_W-1:0]  limit;
    logic              at_limit;
    logic              status_hit;
    logic              select_hit;

    // crystal edges arrive from another timing source, so synchronise first
    crystal_edge_sync u_sync
    (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_pin     (i_crystal_clock),
        .o_rise    (crystal_rise)
    );

    // the counter sees only real edges, so a silent start-up costs nothing
    assign tick = crystal_rise && (mode_q != ST_STOPPED);
    assign clr  = i_stop_exec || i_crystal_osc_stop_set;
    // prohibited codes fall back to the longest time instead of wrapping
    assign limit = thr(sel_exp(sel_q), SCALE_SHIFT);

    stab_counter #(.W(CNT_W)) u_cnt
    (
        .i_sys_clk  (i_sys_clk),
        .i_rst_n    (i_rst_n),
        .i_clr      (clr),
        .i_tick     (tick),
        .i_limit    (limit),
        .o_count    (count),
        .o_at_limit (at_limit)
    );

    // per-flag threshold compare and mask of flags the selection can reach
    for (genvar g = 0; g < FLAG_N; g++)
    begin : g_flag
        assign hit[g] = (count >= thr(flag_exp(g), SCALE_SHIFT));
        assign allowed[g] = (flag_exp(g) <= sel_exp(sel_q));
    end

    // flags are sticky; a clear in the same cycle empties them
    assign status_d = clr ? '0 : (status_q | hit);

    // address decode
    assign status_hit = (i_addr == STATUS_ADDR);
    assign select_hit = (i_addr == SELECT_ADDR);

    // read mux, upper bits of both registers read zero, unmapped reads 00h
    assign rd_mux = status_hit ? {3'h0, status_q} :
                    select_hit ? {5'h00, sel_q} :
                    8'h00;

    // standby sequencing
    always_comb
    begin
        mode_d = mode_q;
        unique case (mode_q)
            ST_RUN:
                if (i_stop_exec)
                    mode_d = ST_STOPPED;
            ST_STOPPED:
                if (i_stop_release)
                    mode_d = ST_WAIT;
            ST_WAIT:
                if (at_limit)
                    mode_d = ST_RUN;
        endcase
    end

    // both oscillators halt while stopped
    assign o_osc_halt = (mode_q == ST_STOPPED);
    // internal oscillator cpu runs on after release; crystal cpu waits
    assign o_cpu_hold = (mode_q == ST_STOPPED) ||
                        ((mode_q == ST_WAIT) && i_cpu_on_crystal &&
                         !at_limit);

    // state, status and select registers
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            mode_q   <= ST_RUN;
            status_q <= STATUS_RST[FLAG_N-1:0];
            sel_q    <= SELECT_RST;
        end
        else
        begin
            mode_q   <= mode_d;
            status_q <= status_d;
            // status is read-only, only the select register takes writes
            if (i_wr && select_hit)
                sel_q <= i_wdata[SEL_W-1:0];
        end
    end

    // read data is registered, one cycle after the read strobe
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            rdata_q  <= 8'h00;
            rd_bit_q <= 1'b0;
        end
        else if (i_rd)
        begin
            rdata_q  <= rd_mux;
            rd_bit_q <= rd_mux[i_bit_idx];
        end
    end

    assign o_rdata  = rdata_q;
    assign o_rd_bit = rd_bit_q;

    // checks on the block's own behaviour
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    property p_clear_on_stop;
        clr |=> (status_q == 5'h00) && (count == '0);
    endproperty
    a_clear_on_stop: assert property (p_clear_on_stop)
        else $error("status not cleared after stop or crystal stop");

    property p_high_bits_zero;
        (i_rd && status_hit) |=> (o_rdata[7:5] == 3'h0) &&
                                 (o_rdata[4:0] == $past(status_q));
    endproperty
    a_high_bits_zero: assert property (p_high_bits_zero)
        else $error("status read returned wrong byte");

    property p_thermometer;
        status_q inside {5'h00, 5'h10, 5'h18, 5'h1c, 5'h1e, 5'h1f};
    endproperty
    a_thermometer: assert property (p_thermometer)
        else $error("status flags not set in ascending order");

    property p_sticky;
        !clr |=> ((status_q & $past(status_q)) == $past(status_q));
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("status flag fell without a clear");

    property p_stop_at_limit;
        (at_limit && !clr && $stable(sel_q)) |=> $stable(count);
    endproperty
    a_stop_at_limit: assert property (p_stop_at_limit)
        else $error("counter advanced beyond selected limit");

    property p_no_far_flag;
        1'b1 |=> ((status_q & ~$past(status_q) & ~allowed) == 5'h00);
    endproperty
    a_no_far_flag: assert property (p_no_far_flag)
        else $error("flag beyond selected time became set");

    property p_reset_values;
        disable iff (1'b0)
        !i_rst_n |=> (sel_q == 3'h5) && (status_q == 5'h00);
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("reset values wrong");

    property p_hold_until_done;
        (mode_q == ST_WAIT && i_cpu_on_crystal && count < limit) |->
            o_cpu_hold ##1 (mode_q == ST_WAIT);
    endproperty
    a_hold_until_done: assert property (p_hold_until_done)
        else $error("cpu released before stabilization time");

    property p_edge_only;
        (!tick && !clr) |=> $stable(count);
    endproperty
    a_edge_only: assert property (p_edge_only)
        else $error("counter moved without a crystal edge");

    property p_bit_read;
        i_rd |=> (o_rd_bit == o_rdata[$past(i_bit_idx)]);
    endproperty
    a_bit_read: assert property (p_bit_read)
        else $error("single bit read disagrees with byte read");

    property p_select_write;
        (i_wr && select_hit) |=> (sel_q == $past(i_wdata[2:0]));
    endproperty
    a_select_write: assert property (p_select_write)
        else $error("select register did not take the write");

    property p_halt_stopped;
        i_stop_exec && mode_q == ST_RUN |=> o_osc_halt && o_cpu_hold;
    endproperty
    a_halt_stopped: assert property (p_halt_stopped)
        else $error("oscillators not halted on stop");

    // with the crystal halted no edge may reach the counter
    property p_stopped_frozen;
        (mode_q == ST_STOPPED && !clr) |=> $stable(count);
    endproperty
    a_stopped_frozen: assert property (p_stopped_frozen)
        else $error("counter moved while stopped");

    property p_release_wait;
        (mode_q == ST_STOPPED && i_stop_release) |=>
            (mode_q == ST_WAIT) && !o_osc_halt;
    endproperty
    a_release_wait: assert property (p_release_wait)
        else $error("stop release did not start the wait");

    property p_wait_done;
        (mode_q == ST_WAIT && count >= limit) |->
            !o_cpu_hold ##1 (mode_q == ST_RUN);
    endproperty
    a_wait_done: assert property (p_wait_done)
        else $error("cpu not released at end of wait");

    property p_internal_no_hold;
        (mode_q == ST_WAIT && !i_cpu_on_crystal) |-> !o_cpu_hold;
    endproperty
    a_internal_no_hold: assert property (p_internal_no_hold)
        else $error("cpu held while on internal oscillator");

    property p_first_flag;
        (!clr && count >= thr(EXP_2P11, SCALE_SHIFT)) |=>
            status_q[POS_2P11];
    endproperty
    a_first_flag: assert property (p_first_flag)
        else $error("first flag missing after its count");

    property p_last_flag;
        (!clr && count >= thr(EXP_2P16, SCALE_SHIFT)) |=>
            status_q[POS_2P16];
    endproperty
    a_last_flag: assert property (p_last_flag)
        else $error("last flag missing after its count");

    property p_flag_needs_count;
        $rose(status_q[POS_2P13]) |->
            ($past(count) >= thr(EXP_2P13, SCALE_SHIFT));
    endproperty
    a_flag_needs_count: assert property (p_flag_needs_count)
        else $error("flag set before its count was reached");

    property p_count_in_range;
        $changed(count) |-> (count == '0) || (count <= limit);
    endproperty
    a_count_in_range: assert property (p_count_in_range)
        else $error("counter moved past the selected limit");

    property p_read_stands;
        !i_rd |=> $stable(o_rdata) && $stable(o_rd_bit);
    endproperty
    a_read_stands: assert property (p_read_stands)
        else $error("read data changed without a read");

    property p_select_read;
        (i_rd && select_hit) |=> (o_rdata == {5'h00, $past(sel_q)});
    endproperty
    a_select_read: assert property (p_select_read)
        else $error("select read returned wrong byte");

endmodule : osc_stab_timer

/* File: test/testbench.sv */
// self-checking testbench for the oscillation stabilization timer
`timescale 1ns/100ps
module testbench;
    import osc_stab_pkg::*;

    // eight crystal edges stand for 2^11 cycles once shortened by 2^8
    localparam int SHIFT = 8;

    // clock, reset, bus and standby controls
    logic        clk          = 1'b0;
    logic        rst_n        = 1'b0;
    logic [15:0] addr         = 16'h0000;
    logic        wr           = 1'b0;
    logic [7:0]  wdata        = 8'h00;
    logic        rd           = 1'b0;
    logic [2:0]  bit_idx      = 3'h0;
    logic        xtal         = 1'b0;
    logic        stop_exec    = 1'b0;
    logic        stop_rel     = 1'b0;
    logic        osc_stop_set = 1'b0;
    logic        on_xtal      = 1'b0;
    logic        xtal_en      = 1'b0;
    logic        xprev        = 1'b0;
    logic [7:0]  rdata;
    logic        rd_bit;
    logic        osc_halt;
    logic        cpu_hold;
    logic [7:0]  rb;
    logic        rbit;
    int          xdiv         = 0;
    int          xedges       = 0;
    int          n_fail       = 0;
    int          n_compared   = 0;

    osc_stab_timer #(.SCALE_SHIFT(SHIFT)) DUT (
        .i_sys_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wr(wr),
        .i_wdata(wdata), .i_rd(rd), .i_bit_idx(bit_idx), .o_rdata(rdata),
        .o_rd_bit(rd_bit), .i_crystal_clock(xtal), .i_stop_exec(stop_exec),
        .i_stop_release(stop_rel), .i_crystal_osc_stop_set(osc_stop_set),
        .i_cpu_on_crystal(on_xtal), .o_osc_halt(osc_halt),
        .o_cpu_hold(cpu_hold)
    );

    always #12.5 clk = ~clk;

    // crystal toggles every 3 clocks so each level lasts past the sync
    always @(posedge clk)
    begin
        if (xtal_en)
        begin
            if (xdiv == 2)
            begin
                xdiv <= 0;
                xtal <= ~xtal;
            end
            else
                xdiv <= xdiv + 1;
        end
    end

    // count crystal rising edges as the device should see them
    always @(posedge clk)
    begin
        xprev <= xtal;
        if (xtal && !xprev)
            xedges <= xedges + 1;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: %s got %h want %h",
                     $time, what, got, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // read data is registered, so it is sampled just after the taking edge
    task automatic rd_reg(input logic [15:0] a, input logic [2:0] b);
        @(posedge clk);
        addr    <= a;
        bit_idx <= b;
        rd      <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        rb   = rdata;
        rbit = rd_bit;
    endtask : rd_reg

    // 0 stop instruction, 1 stop release, 2 crystal stop bit written
    task automatic pulse(input int which);
        @(posedge clk);
        stop_exec    <= (which == 0);
        stop_rel     <= (which == 1);
        osc_stop_set <= (which == 2);
        @(posedge clk);
        stop_exec    <= 1'b0;
        stop_rel     <= 1'b0;
        osc_stop_set <= 1'b0;
        #1;
    endtask : pulse

    task automatic t_reset;
        #1;
        check(osc_halt, 0, "halt after reset");
        check(cpu_hold, 0, "hold after reset");
        rd_reg(STATUS_ADDR, 3'h0);
        check(rb, 8'h00, "status reset");
        rd_reg(SELECT_ADDR, 3'h0);
        check(rb, 8'h05, "select reset");
        wr_reg(STATUS_ADDR, 8'hff);
        rd_reg(STATUS_ADDR, 3'h0);
        check(rb, 8'h00, "status write ignored");
        rd_reg(16'hffa5, 3'h0);
        check(rb, 8'h00, "unmapped read");
        $display("test reset done");
    endtask : t_reset

    task automatic t_select;
        for (int c = 1; c <= 5; c++)
        begin
            wr_reg(SELECT_ADDR, 8'(c));
            rd_reg(SELECT_ADDR, 3'h0);
            check(rb, 8'(c), "select readback");
        end
        wr_reg(SELECT_ADDR, 8'hff);
        rd_reg(SELECT_ADDR, 3'h0);
        check(rb, 8'h07, "select upper bits");
        wr_reg(SELECT_ADDR, 8'h05);
        wr_reg(16'hffa5, 8'h02);
        rd_reg(SELECT_ADDR, 3'h0);
        check(rb, 8'h05, "unmapped write");
        $display("test select done");
    endtask : t_select

    task automatic t_clear;
        @(posedge clk) xtal_en <= 1'b1;
        repeat (100) @(posedge clk);
        rd_reg(STATUS_ADDR, 3'h0);
        check(rb, 8'h10, "first flag only");
        pulse(2);
        rd_reg(STATUS_ADDR, 3'h0);
        check(rb, 8'h00, "crystal stop clear");
        wr_reg(SELECT_ADDR, 8'h03);
        @(posedge clk) xtal_en <= 1'b0;
        @(posedge clk) rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(STATUS_ADDR, 3'h0);
        check(rb, 8'h00, "status mid reset");
        rd_reg(SELECT_ADDR, 3'h0);
        check(rb, 8'h05, "select mid reset");
        $display("test clear done");
    endtask : t_clear

    // crystal drives the cpu: held until the selected count, then frozen
    task automatic t_stop_wait(input int code);
        int         exps[6] = '{16, 11, 13, 14, 15, 16};
        int         lim;
        int         e0;
        int         i;
        logic [4:0] m;
        logic [7:0] want;
        lim  = 1 << (exps[code] - SHIFT);
        m    = ~(5'h1f >> code);
        want = {3'h0, m};
        wr_reg(SELECT_ADDR, 8'(code));
        @(posedge clk);
        xtal_en <= 1'b0;
        on_xtal <= 1'b1;
        repeat (6) @(posedge clk);
        pulse(0);
        check(osc_halt, 1, "halt in stop");
        rd_reg(STATUS_ADDR, 3'h0);
        check(rb, 8'h00, "stop clears status");
        pulse(1);
        check(osc_halt, 0, "halt after release");
        repeat (20) @(posedge clk);
        #1;
        check(cpu_hold, 1, "held before crystal starts");
        e0 = xedges;
        @(posedge clk) xtal_en <= 1'b1;
        for (i = 0; i < 3000 && cpu_hold !== 1'b0; i++)
        begin
            @(posedge clk);
            #1;
        end
        check(16'(xedges - e0), 16'(lim), "edges at hold end");
        repeat (300) @(posedge clk);
        rd_reg(STATUS_ADDR, 3'h0);
        check(rb, {3'h0, m}, "flags up to selection");
        for (int b = 0; b < 8; b++)
        begin
            rd_reg(STATUS_ADDR, 3'(b));
            check(rbit, want[b], "single bit read");
        end
        $display("test stop wait %0d done", code);
    endtask : t_stop_wait

    // internal oscillator drives the cpu: no hold, software polls flags
    task automatic t_poll;
        logic [7:0] prev;
        logic       ok;
        prev = 8'h00;
        wr_reg(SELECT_ADDR, 8'h05);
        @(posedge clk);
        xtal_en <= 1'b0;
        on_xtal <= 1'b0;
        pulse(0);
        pulse(1);
        check(cpu_hold, 0, "no hold on internal clock");
        @(posedge clk) xtal_en <= 1'b1;
        for (int i = 0; i < 1000 && prev !== 8'h1f; i++)
        begin
            rd_reg(STATUS_ADDR, 3'h0);
            ok = (rb inside {8'h00, 8'h10, 8'h18, 8'h1c, 8'h1e, 8'h1f})
                 && (rb >= prev);
            check(ok, 1, "ascending sticky flags");
            prev = rb;
        end
        check(prev, 8'h1f, "all flags set");
        $display("test poll done");
    endtask : t_poll

    task automatic conclude;
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude

    // watchdog sized well past the roughly 6500 cycles the tests need
    initial
    begin
        repeat (40000) @(posedge clk);
        n_fail++;
        $display("unexpected at %0t: watchdog expired", $time);
        conclude();
    end

    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_select();
        t_clear();
        for (int c = 1; c <= 5; c++)
            t_stop_wait(c);
        t_poll();
        conclude();
    end

endmodule : testbench
